//--- rtl/xss_ctrl.sv
// Extended-state save/restore decision logic for one core.
// Assumes the core issues one operation pulse at a time and waits for done.
//
// Summary of operation
// - Restore mask low bits clear: touch nothing
// - Save mask low bits clear: store nothing
// - Restore FP: load if header set, else init
// - Restore vector: load csr, regs per header
// - Reject loaded vector csr with reserved bits
// - Save FP on mask0; vector needs mask1 and enable1
// - Task-switched flag raises device-not-available fault on save/restore with a low mask bit set and on legacy vector ops
// - Clearing enable bit 0 gives protection fault
// - Mirror OS enable into capability bit 27
// - OS enable needs save support capability
// - Mask read returns enable register in pair
// - Upper components need enables else undefined fault
// - Leaf 0DH reports supported bits and size
// - Legacy 512-byte layout shared with legacy ops
// - Legacy vector ops gated by legacy control
// - Present bit set means area was written
// - Enable register readable anywhere, written top only
`timescale 1ns/100ps
`default_nettype none
module xss_ctrl
    import xss_pkg::*;
#(
    parameter int                W           = XSS_MASK_W,
    parameter logic [63:0]       SUPPORTED   = 64'h0000000000000003,
    parameter int                EXT_BYTES   = 0,
    parameter bit                XS_SUPPORT  = 1'b1
)
(
    input  wire logic            core_clk,
    input  wire logic            reset,
    input  wire logic            op_valid,
    input  wire xss_op_t         op_code,
    input  wire logic [W-1:0]    op_mask,
    input  wire logic [5:0]      op_comp,
    input  wire logic [1:0]      priv_level,
    input  wire logic            task_switched_flag,
    input  wire logic            os_legacy_vector_enable,
    input  wire logic            os_ext_state_enable_wr,
    input  wire logic            os_ext_state_enable_val,
    input  wire logic [W-1:0]    hdr_state_present_vector,
    input  wire logic [31:0]     mem_vector_ctrl_status,
    input  wire logic [31:0]     cap_leaf,
    input  wire logic [31:0]     cap_subleaf,
    output logic                 op_done,
    output logic                 device_not_available_fault,
    output logic                 general_protection_fault,
    output logic                 undefined_opcode_fault,
    output xss_act_t             fp_action,
    output xss_act_t             vec_regs_action,
    output xss_act_t             vec_csr_action,
    output logic [W-1:0]         new_state_present_vector,
    output logic [31:0]          result_eax,
    output logic [31:0]          result_edx,
    output logic [31:0]          cap_ecx,
    output logic [31:0]          cap_ebx,
    output logic                 os_ext_state_enable,
    output logic [31:0]          vector_ctrl_status_reg
);
    localparam int SAVE_BYTES = XSS_LEGACY_BYTES + XSS_HEADER_BYTES + EXT_BYTES;

    logic [W-1:0] feature_enable_reg;
    logic         fen_wr;
    logic [W-1:0] fen_wr_data;
    xss_state_t   state;
    logic         ts_hit;
    logic         m0;
    logic         m1;
    logic         vcsr_bad;

    xss_fen_store #(.W(W)) u_fen
    (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (fen_wr),
        .wr_data  (fen_wr_data),
        .rd_data  (feature_enable_reg)
    );

    assign m0 = op_mask[XSS_FP_BIT];
    assign m1 = op_mask[XSS_VEC_BIT];
    assign ts_hit = task_switched_flag & (m0 | m1);
    assign vcsr_bad = |(mem_vector_ctrl_status & XSS_VCSR_RESERVED);
    assign fen_wr_data = op_mask;

    // Accepted write: top privilege, bit 0 kept, only supported bits
    assign fen_wr = (state == XSS_ST_IDLE) && op_valid && op_code == XSS_OP_MASK_WR
                    && os_ext_state_enable && priv_level == XSS_PRIV_TOP
                    && op_mask[XSS_FP_BIT]
                    && ((op_mask & ~SUPPORTED[W-1:0]) == '0);

    always_ff @(posedge core_clk)
    begin
        if (reset)
            state <= XSS_ST_IDLE;
        else
        begin
            case (state)
                XSS_ST_IDLE: if (op_valid) state <= XSS_ST_EXEC;
                XSS_ST_EXEC: state <= XSS_ST_DONE;
                XSS_ST_DONE: state <= XSS_ST_IDLE;
                default:     state <= XSS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            os_ext_state_enable <= 1'b0;
        else if (os_ext_state_enable_wr)
            os_ext_state_enable <= os_ext_state_enable_val & XS_SUPPORT;
    end

    // Operation decode; results settle one cycle after the request
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            op_done                    <= 1'b0;
            device_not_available_fault <= 1'b0;
            general_protection_fault   <= 1'b0;
            undefined_opcode_fault     <= 1'b0;
            fp_action                  <= XSS_ACT_NONE;
            vec_regs_action            <= XSS_ACT_NONE;
            vec_csr_action             <= XSS_ACT_NONE;
            new_state_present_vector   <= '0;
            result_eax                 <= '0;
            result_edx                 <= '0;
            vector_ctrl_status_reg     <= XSS_VCSR_INIT;
        end
        else
        begin
            op_done                    <= 1'b0;
            device_not_available_fault <= 1'b0;
            general_protection_fault   <= 1'b0;
            undefined_opcode_fault     <= 1'b0;
            fp_action                  <= XSS_ACT_NONE;
            vec_regs_action            <= XSS_ACT_NONE;
            vec_csr_action             <= XSS_ACT_NONE;
            if (state == XSS_ST_IDLE && op_valid)
            begin
                op_done <= 1'b1;
                case (op_code)
                    XSS_OP_STORE:
                    begin
                        if (!os_ext_state_enable)
                            undefined_opcode_fault <= 1'b1;
                        else if (ts_hit)
                            device_not_available_fault <= 1'b1;
                        else
                        begin
                            // Untouched header bits pass through unchanged
                            new_state_present_vector <= hdr_state_present_vector;
                            if (m0)
                            begin
                                fp_action <= XSS_ACT_STORE;
                                new_state_present_vector[XSS_FP_BIT] <= 1'b1;
                            end
                            if (m1 && feature_enable_reg[XSS_VEC_BIT])
                            begin
                                vec_regs_action <= XSS_ACT_STORE;
                                vec_csr_action  <= XSS_ACT_STORE;
                                new_state_present_vector[XSS_VEC_BIT] <= 1'b1;
                            end
                        end
                    end
                    XSS_OP_LOAD:
                    begin
                        if (!os_ext_state_enable)
                            undefined_opcode_fault <= 1'b1;
                        else if (ts_hit)
                            device_not_available_fault <= 1'b1;
                        else if (m1 && vcsr_bad)
                            general_protection_fault <= 1'b1;
                        else
                        begin
                            if (m0)
                                fp_action <= hdr_state_present_vector[XSS_FP_BIT]
                                             ? XSS_ACT_LOAD : XSS_ACT_INIT;
                            if (m1)
                            begin
                                vec_csr_action <= XSS_ACT_LOAD;
                                vector_ctrl_status_reg <= mem_vector_ctrl_status;
                                vec_regs_action <= hdr_state_present_vector[XSS_VEC_BIT]
                                                   ? XSS_ACT_LOAD : XSS_ACT_INIT;
                            end
                        end
                    end
                    XSS_OP_MASK_RD:
                    begin
                        if (!os_ext_state_enable)
                            undefined_opcode_fault <= 1'b1;
                        else
                        begin
                            result_eax <= feature_enable_reg[31:0];
                            result_edx <= feature_enable_reg[63:32];
                        end
                    end
                    XSS_OP_MASK_WR:
                    begin
                        if (!os_ext_state_enable)
                            undefined_opcode_fault <= 1'b1;
                        else if (!fen_wr)
                            general_protection_fault <= 1'b1;
                    end
                    XSS_OP_EXT_INST:
                    begin
                        // Component above bit 1 needs OS control, enable and support
                        if (op_comp > 6'(XSS_VEC_BIT) && (!os_ext_state_enable
                            || !feature_enable_reg[op_comp] || !SUPPORTED[op_comp]))
                            undefined_opcode_fault <= 1'b1;
                        else if (op_comp <= 6'(XSS_VEC_BIT) && !os_legacy_vector_enable)
                            undefined_opcode_fault <= 1'b1;
                    end
                    XSS_OP_LEG_VEC:
                    begin
                        // Feature-enable register plays no part here
                        if (!os_legacy_vector_enable)
                            undefined_opcode_fault <= 1'b1;
                        else if (task_switched_flag)
                            device_not_available_fault <= 1'b1;
                    end
                    default:
                        undefined_opcode_fault <= 1'b1;
                endcase
            end
        end
    end

    // Capability answers, recomputed every cycle from the query inputs
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cap_ecx <= '0;
            cap_ebx <= '0;
        end
        else if (cap_leaf == XSS_LEAF_BASIC)
        begin
            cap_ecx <= '0;
            cap_ecx[XSS_CAP_XS_BIT]   <= XS_SUPPORT;
            cap_ecx[XSS_CAP_OSXS_BIT] <= os_ext_state_enable;
            cap_ebx <= '0;
        end
        else if (cap_leaf == XSS_LEAF_EXT_STATE && cap_subleaf == '0)
        begin
            cap_ecx <= 32'(SAVE_BYTES);
            cap_ebx <= SUPPORTED[31:0];
        end
        else
        begin
            cap_ecx <= '0;
            cap_ebx <= '0;
        end
    end
endmodule : xss_ctrl
`default_nettype wire

//--- rtl/xss_pkg.sv
// Package for the extended-state save/restore control block.
// Assumes one core clock and a synchronous active-high reset.
package xss_pkg;
    localparam int XSS_MASK_W        = 64;
    localparam int XSS_FP_BIT        = 0;
    localparam int XSS_VEC_BIT       = 1;
    localparam int XSS_LEGACY_BYTES  = 512;
    localparam int XSS_HEADER_BYTES  = 64;
    localparam int XSS_CAP_OSXS_BIT  = 27;
    localparam int XSS_CAP_XS_BIT    = 26;
    localparam logic [63:0] XSS_FEN_RESET      = 64'h0000000000000001;
    localparam logic [31:0] XSS_VCSR_RESERVED  = 32'hFFFF0000;
    localparam logic [31:0] XSS_VCSR_INIT      = 32'h00001F80;
    localparam logic [31:0] XSS_LEAF_BASIC     = 32'h00000001;
    localparam logic [31:0] XSS_LEAF_EXT_STATE = 32'h0000000D;
    localparam logic [1:0]  XSS_PRIV_TOP       = 2'h0;

    typedef enum logic [2:0]
    {
        XSS_OP_NONE     = 3'h0,
        XSS_OP_STORE    = 3'h1,
        XSS_OP_LOAD     = 3'h2,
        XSS_OP_MASK_RD  = 3'h3,
        XSS_OP_MASK_WR  = 3'h4,
        XSS_OP_EXT_INST = 3'h5,
        XSS_OP_LEG_VEC  = 3'h6
    } xss_op_t;

    typedef enum logic [1:0]
    {
        XSS_ACT_NONE = 2'h0,
        XSS_ACT_LOAD = 2'h1,
        XSS_ACT_INIT = 2'h2,
        XSS_ACT_STORE = 2'h3
    } xss_act_t;

    typedef enum logic [1:0]
    {
        XSS_ST_IDLE = 2'b00,
        XSS_ST_EXEC = 2'b01,
        XSS_ST_DONE = 2'b11
    } xss_state_t;
endpackage : xss_pkg

//--- rtl/xss_fen_store.sv
// Feature-enable register storage; bit 0 is forced to one.
// Assumes the caller has already vetted the write.
`timescale 1ns/100ps
`default_nettype none
module xss_fen_store
    import xss_pkg::*;
#(
    parameter int W = XSS_MASK_W
)
(
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] rd_data
);
    always_ff @(posedge core_clk)
    begin
        if (reset)
            rd_data <= XSS_FEN_RESET[W-1:0];
        else if (wr_en)
            rd_data <= wr_data | XSS_FEN_RESET[W-1:0];
    end
endmodule : xss_fen_store
`default_nettype wire

//--- tb/xss_ctrl_props.sv
// Assertion checker for the save/restore control block.
// Bound into every xss_ctrl; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module xss_ctrl_props
    import xss_pkg::*;
#(
    parameter int          W          = XSS_MASK_W,
    parameter logic [63:0] SUPPORTED  = 64'h0000000000000003,
    parameter int          EXT_BYTES  = 0,
    parameter bit          XS_SUPPORT = 1'b1
)
(
    input wire logic         core_clk,
    input wire logic         reset,
    input wire logic         op_valid,
    input wire xss_op_t      op_code,
    input wire logic [W-1:0] op_mask,
    input wire logic [5:0]   op_comp,
    input wire logic         task_switched_flag,
    input wire logic         os_ext_state_enable_wr,
    input wire logic         os_ext_state_enable_val,
    input wire logic [W-1:0] hdr_state_present_vector,
    input wire logic [31:0]  mem_vector_ctrl_status,
    input wire logic [31:0]  cap_leaf,
    input wire logic [31:0]  cap_subleaf,
    input wire logic         op_done,
    input wire logic         device_not_available_fault,
    input wire logic         general_protection_fault,
    input wire logic         undefined_opcode_fault,
    input wire xss_act_t     fp_action,
    input wire xss_act_t     vec_regs_action,
    input wire xss_act_t     vec_csr_action,
    input wire logic [31:0]  cap_ecx,
    input wire logic [31:0]  cap_ebx,
    input wire logic         os_ext_state_enable,
    input wire logic [31:0]  vector_ctrl_status_reg
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (reset);
// Requests inside the two-cycle shadow are ignored, so only count real takes
logic [1:0] gap;
wire take = op_valid && gap == 2'h0;
wire live = os_ext_state_enable && !task_switched_flag;
wire ld   = take && op_code == XSS_OP_LOAD;
wire st   = take && op_code == XSS_OP_STORE;
wire none = fp_action == XSS_ACT_NONE && vec_csr_action == XSS_ACT_NONE;
always_ff @(posedge core_clk) gap <= reset ? 2'h0 : (take ? 2'h2 : gap - {1'b0, gap != 2'h0});
a_take_done: assert property (take |=> op_done) else $error("No done after request");
a_load_idle: assert property (ld && op_mask[1:0] == 2'h0 |=> none && vec_regs_action == XSS_ACT_NONE)
    else $error("Load with empty mask acted");
a_store_idle: assert property (st && op_mask[1:0] == 2'h0 |=> none && vec_regs_action == XSS_ACT_NONE)
    else $error("Store with empty mask acted");
a_load_fp_pick: assert property (ld && live && op_mask[1:0] == 2'h1
    |=> fp_action == ($past(hdr_state_present_vector[0]) ? XSS_ACT_LOAD : XSS_ACT_INIT))
    else $error("Wrong fp restore action");
a_load_vec_pick: assert property (ld && live && op_mask[1] && mem_vector_ctrl_status[31:16] == 16'h0
    |=> vec_csr_action == XSS_ACT_LOAD && vector_ctrl_status_reg == $past(mem_vector_ctrl_status)
    && vec_regs_action == ($past(hdr_state_present_vector[1]) ? XSS_ACT_LOAD : XSS_ACT_INIT))
    else $error("Wrong vector restore action");
a_csr_reject: assert property (ld && live && op_mask[1] && mem_vector_ctrl_status[31:16] != 16'h0
    |=> general_protection_fault && none && $stable(vector_ctrl_status_reg))
    else $error("Reserved csr image accepted");
a_store_fp: assert property (st && live
    |=> fp_action == ($past(op_mask[0]) ? XSS_ACT_STORE : XSS_ACT_NONE)) else $error("Wrong fp store");
a_ts_fault: assert property (take && (op_code == XSS_OP_LOAD || op_code == XSS_OP_STORE)
    && os_ext_state_enable && task_switched_flag && op_mask[1:0] != 2'h0
    |=> device_not_available_fault && none) else $error("Task-switched op not faulted");
a_bit0_clear: assert property (take && op_code == XSS_OP_MASK_WR && os_ext_state_enable && !op_mask[0]
    |=> general_protection_fault) else $error("Enable bit 0 clear accepted");
a_cap_mirror: assert property (cap_leaf == XSS_LEAF_BASIC |=> cap_ecx[XSS_CAP_XS_BIT] == XS_SUPPORT
    && cap_ecx[XSS_CAP_OSXS_BIT] == $past(os_ext_state_enable)) else $error("Capability bits wrong");
a_os_write: assert property (os_ext_state_enable_wr
    |=> os_ext_state_enable == ($past(os_ext_state_enable_val) && XS_SUPPORT)) else $error("OS enable wrong");
a_ext_undef: assert property (take && op_code == XSS_OP_EXT_INST && op_comp > 6'h1
    && !os_ext_state_enable |=> undefined_opcode_fault) else $error("Upper component not refused");
a_leaf_size: assert property (cap_leaf == XSS_LEAF_EXT_STATE && cap_subleaf == 32'h0
    |=> cap_ecx == XSS_LEGACY_BYTES + XSS_HEADER_BYTES + EXT_BYTES && cap_ebx == SUPPORTED[31:0])
    else $error("Leaf size report wrong");
endmodule : xss_ctrl_props
bind xss_ctrl xss_ctrl_props #(.W(W), .SUPPORTED(SUPPORTED), .EXT_BYTES(EXT_BYTES),
    .XS_SUPPORT(XS_SUPPORT)) u_props (.core_clk, .reset, .op_valid, .op_code, .op_mask, .op_comp,
    .task_switched_flag, .os_ext_state_enable_wr, .os_ext_state_enable_val, .hdr_state_present_vector,
    .mem_vector_ctrl_status, .cap_leaf, .cap_subleaf, .op_done, .device_not_available_fault,
    .general_protection_fault, .undefined_opcode_fault, .fp_action, .vec_regs_action, .vec_csr_action,
    .cap_ecx, .cap_ebx, .os_ext_state_enable, .vector_ctrl_status_reg);
`default_nettype wire

//--- tb/xss_ctrl_bench.sv
// Self-checking bench for the save/restore control block.
// Drives every input at the falling edge; the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
module xss_ctrl_bench
    import xss_pkg::*;
;
    logic        core_clk = 1'b0, reset = 1'b1, op_valid = 1'b0, task_switched_flag = 1'b0;
    logic        os_legacy_vector_enable = 1'b1, os_ext_state_enable_wr = 1'b0;
    logic        os_ext_state_enable_val = 1'b0, hit, bad, ok;
    xss_op_t     op_code = XSS_OP_NONE;
    logic [63:0] op_mask = 64'h0, hdr_state_present_vector = 64'h0, m;
    logic [5:0]  op_comp = 6'h0;
    logic [1:0]  priv_level = 2'h0;
    logic [31:0] mem_vector_ctrl_status = 32'h1F80, cap_leaf = 32'h0, cap_subleaf = 32'h0;
    logic        op_done, device_not_available_fault, general_protection_fault;
    logic        undefined_opcode_fault, os_ext_state_enable;
    xss_act_t    fp_action, vec_regs_action, vec_csr_action;
    logic [63:0] new_state_present_vector;
    logic [31:0] result_eax, result_edx, cap_ecx, cap_ebx, vector_ctrl_status_reg;
    logic [15:0] r = 16'h1F0A;
    int          n_errors = 0, samples_checked = 0, cyc = 0;
    xss_ctrl dut_u (.core_clk, .reset, .op_valid, .op_code, .op_mask, .op_comp, .priv_level,
        .task_switched_flag, .os_legacy_vector_enable, .os_ext_state_enable_wr,
        .os_ext_state_enable_val, .hdr_state_present_vector, .mem_vector_ctrl_status, .cap_leaf,
        .cap_subleaf, .op_done, .device_not_available_fault, .general_protection_fault,
        .undefined_opcode_fault, .fp_action, .vec_regs_action, .vec_csr_action,
        .new_state_present_vector, .result_eax, .result_edx, .cap_ecx, .cap_ebx,
        .os_ext_state_enable, .vector_ctrl_status_reg);
    initial forever #5 core_clk = ~core_clk;
    task automatic close_out;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    // A hung handshake would otherwise stall the run forever
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            close_out();
        end
    end
    function automatic logic [15:0] nxt(input logic [15:0] x);
        nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nxt
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Two idle edges clear the previous take's shadow; returns while the pulses stand
    task automatic op(input xss_op_t c, input logic [63:0] v);
        repeat (2) @(negedge core_clk);
        op_code = c;
        op_mask = v;
        op_valid = 1'b1;
        @(negedge core_clk);
        op_valid = 1'b0;
    endtask : op
    task automatic cap(input logic [31:0] leaf);
        @(negedge core_clk);
        cap_leaf = leaf;
        @(negedge core_clk);
    endtask : cap
    task automatic osw(input logic v);
        @(negedge core_clk);
        os_ext_state_enable_wr = 1'b1;
        os_ext_state_enable_val = v;
        @(negedge core_clk);
        os_ext_state_enable_wr = 1'b0;
    endtask : osw
    function automatic logic [5:0] exp_ld(input logic [1:0] k, input logic [1:0] h);
        exp_ld = {k[0] ? (h[0] ? 2'h1 : 2'h2) : 2'h0, k[1] ? (h[1] ? 2'h1 : 2'h2) : 2'h0, 1'b0, k[1]};
    endfunction : exp_ld
    initial
    begin
        repeat (16) @(negedge core_clk);
        reset = 1'b0;
        chk(vector_ctrl_status_reg, 64'h1F80);
        cap(XSS_LEAF_BASIC);
        chk(cap_ecx[27:26], 64'h1);
        osw(1'b1);
        cap(XSS_LEAF_BASIC);
        chk(cap_ecx[27:26], 64'h3);
        cap(XSS_LEAF_EXT_STATE);
        chk({cap_ebx, cap_ecx}, {32'h3, 32'h240});
        priv_level = 2'h3;
        op(XSS_OP_MASK_WR, 64'h3);
        chk(general_protection_fault, 64'h1);
        priv_level = 2'h0;
        for (int i = 0; i < 3; i++)
        begin
            op(XSS_OP_MASK_WR, i * 2);
            chk(general_protection_fault, 64'h1);
        end
        op(XSS_OP_MASK_WR, 64'h3);
        priv_level = 2'h3;
        op(XSS_OP_MASK_RD, 64'h0);
        chk({result_edx, result_eax}, 64'h3);
        priv_level = 2'h0;
        repeat (200)
        begin
            r = nxt(r);
            hdr_state_present_vector = {62'h0, r[4:3]};
            mem_vector_ctrl_status = (r[7:5] == 3'h0) ? 32'h11F80 : {16'h0, r[15:8], 8'h80};
            task_switched_flag = r[10:9] == 2'h0;
            m = {62'h0, r[2:1]};
            op(r[0] ? XSS_OP_LOAD : XSS_OP_STORE, m);
            hit = task_switched_flag && m[1:0] != 2'h0;
            bad = !hit && r[0] && m[1] && r[7:5] == 3'h0;
            ok = !hit && !bad;
            chk({device_not_available_fault, general_protection_fault}, {hit, bad});
            if (r[0])
                chk({fp_action, vec_regs_action, vec_csr_action}, exp_ld(m[1:0] & {2{ok}}, r[4:3]));
            else
                chk({fp_action, vec_regs_action, vec_csr_action}, {{2{ok & m[0]}}, {4{ok & m[1]}}});
            if (ok && !r[0])
                chk(new_state_present_vector, hdr_state_present_vector | m);
        end
        task_switched_flag = 1'b0;
        hdr_state_present_vector = 64'h0;
        op(XSS_OP_MASK_WR, 64'h1);
        op(XSS_OP_STORE, 64'h3);
        chk({fp_action, vec_regs_action, vec_csr_action}, 6'h30);
        chk(new_state_present_vector, 64'h1);
        mem_vector_ctrl_status = 32'h00001FC0;
        op(XSS_OP_LOAD, '1);
        chk({fp_action, vec_regs_action, vec_csr_action}, exp_ld(2'h3, 2'h0));
        chk(vector_ctrl_status_reg, 64'h1FC0);
        op_comp = 6'h2;
        op(XSS_OP_EXT_INST, 64'h0);
        chk(undefined_opcode_fault, 64'h1);
        op_comp = 6'h1;
        op(XSS_OP_EXT_INST, 64'h0);
        chk(undefined_opcode_fault, 64'h0);
        os_legacy_vector_enable = 1'b0;
        op(XSS_OP_EXT_INST, 64'h0);
        chk(undefined_opcode_fault, 64'h1);
        osw(1'b0);
        op_comp = 6'h2;
        op(XSS_OP_EXT_INST, 64'h0);
        chk(undefined_opcode_fault, 64'h1);
        os_legacy_vector_enable = 1'b1;
        op(XSS_OP_LEG_VEC, 64'h0);
        chk(undefined_opcode_fault, 64'h0);
        os_legacy_vector_enable = 1'b0;
        op(XSS_OP_LEG_VEC, 64'h0);
        chk(undefined_opcode_fault, 64'h1);
        close_out();
    end
endmodule : xss_ctrl_bench
`default_nettype wire
